/* common/qei_pkg.sv */
`default_nettype none
package qenc_pkg;
	// mode field encodings
	localparam logic [2:0] MODE_OFF      = 3'h0;
	localparam logic [2:0] MODE_TIMER    = 3'h1;
	localparam logic [2:0] MODE_X2_INDEX = 3'h4;
	localparam logic [2:0] MODE_X2_MATCH = 3'h5;
	localparam logic [2:0] MODE_X4_INDEX = 3'h6;
	localparam logic [2:0] MODE_X4_MATCH = 3'h7;
	// control register field positions
	localparam int CTL_MODE_LSB = 8;
	localparam int CTL_MODE_MSB = 10;
	localparam int CTL_DIR_BIT  = 11;
	localparam int CTL_DSRC_BIT = 0;
	// filter control field positions
	localparam int FLT_DIV_LSB = 4;
	localparam int FLT_DIV_MSB = 6;
	// filter needs this many equal samples
	localparam int FLT_STABLE_CNT = 3;
	// reset values
	localparam logic [15:0] POS_RESET = 16'h0000;
	localparam logic [7:0]  DIV_RESET = 8'h00;
endpackage : qenc_pkg
`default_nettype wire

/* core/qei_encoder_interface.sv */
`default_nettype none
module qenc_encoder_interface
	import qenc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        brownOutResetn,
	input  wire logic [15:0] encoderControlRegister,
	input  wire logic [15:0] filterControlRegister,
	input  wire logic        filterOutputEnable,
	input  wire logic [15:0] maximumCountRegister,
	input  wire logic        cpuSleep,
	input  wire logic        phaseAInput,
	input  wire logic        phaseBInput,
	input  wire logic        indexInput,
	output logic      [15:0] positionCount_q,
	output logic             countDirection_q,
	output logic             matchEvent_q
);
	////////////////////////////////////////////////////////////////////////////
	logic [1:0] sA_q, sB_q, sI_q;   // [0] first stage, [1] second stage
	logic [7:0] divCnt_q;
	logic       fltTick;
	logic [1:0] fA_q, fB_q, fI_q;   // sample histories
	logic       oA_q, oB_q, oI_q;   // filtered levels
	logic       fltEn_q;
	logic       pA, pB, pI, pAprev_q, pBprev_q, pIprev_q;
	logic [2:0] mode;
	logic       edgeA, edgeB, stepUp, stepEn, isMatch, useMatch, useIndex;
	logic       rstAll;

	assign rstAll = resetn & brownOutResetn;
	assign mode   = encoderControlRegister[CTL_MODE_MSB:CTL_MODE_LSB];

	// ratio 2^field; divider frozen in sleep since clocks stop
	function automatic logic [7:0] divLimit(input logic [2:0] f);
		divLimit = 8'(({7'h00, 1'b1} << f) - 8'h01);
	endfunction : divLimit

	// filter: new level only after three equal samples
	function automatic logic fltNext(input logic [1:0] h, input logic s, input logic o);
		fltNext = (h[0] == s && h[1] == s) ? s : o;
	endfunction : fltNext

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops before any logic reads the pins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sA_q <= 2'h0;
			sB_q <= 2'h0;
			sI_q <= 2'h0;
		end else begin
			sA_q <= {sA_q[0], phaseAInput};
			sB_q <= {sB_q[0], phaseBInput};
			sI_q <= {sI_q[0], indexInput};
		end
	end

	// filter clock divider
	always_ff @(posedge clk_sys or negedge rstAll) begin
		if (!rstAll) begin
			divCnt_q <= DIV_RESET;
		end else if (cpuSleep) begin
			divCnt_q <= divCnt_q;
		end else if (divCnt_q >= divLimit(filterControlRegister[FLT_DIV_MSB:FLT_DIV_LSB])) begin
			divCnt_q <= DIV_RESET;
		end else begin
			divCnt_q <= divCnt_q + 8'h01;
		end
	end
	assign fltTick = (divCnt_q >= divLimit(filterControlRegister[FLT_DIV_MSB:FLT_DIV_LSB]))
			& ~cpuSleep;

	// filter enable is cleared by either reset and re-armed from the port afterwards
	always_ff @(posedge clk_sys or negedge rstAll) begin
		if (!rstAll) begin
			fltEn_q <= 1'b0;
		end else begin
			fltEn_q <= filterOutputEnable;
		end
	end

	// three-sample filters on all channels; while switched off they follow the pins,
	// so that switching on after a brown-out never shows the decoder a false edge
	always_ff @(posedge clk_sys or negedge rstAll) begin
		if (!rstAll) begin
			fA_q <= 2'h0;
			fB_q <= 2'h0;
			fI_q <= 2'h0;
			oA_q <= 1'b0;
			oB_q <= 1'b0;
			oI_q <= 1'b0;
		end else if (!fltEn_q) begin
			fA_q <= {2{sA_q[1]}};
			fB_q <= {2{sB_q[1]}};
			fI_q <= {2{sI_q[1]}};
			oA_q <= sA_q[1];
			oB_q <= sB_q[1];
			oI_q <= sI_q[1];
		end else if (fltTick) begin
			fA_q <= {fA_q[0], sA_q[1]};
			fB_q <= {fB_q[0], sB_q[1]};
			fI_q <= {fI_q[0], sI_q[1]};
			oA_q <= fltNext(fA_q, sA_q[1], oA_q);
			oB_q <= fltNext(fB_q, sB_q[1], oB_q);
			oI_q <= fltNext(fI_q, sI_q[1], oI_q);
		end
	end

	// decoder sees filtered levels only while enabled
	assign pA = fltEn_q ? oA_q : sA_q[1];
	assign pB = fltEn_q ? oB_q : sB_q[1];
	assign pI = fltEn_q ? oI_q : sI_q[1];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pAprev_q <= 1'b0;
			pBprev_q <= 1'b0;
			pIprev_q <= 1'b0;
		end else if (!cpuSleep) begin
			pAprev_q <= pA;
			pBprev_q <= pB;
			pIprev_q <= pI;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// step decode: A leads B means up; other phase level judges direction
	assign edgeA = pA ^ pAprev_q;
	assign edgeB = pB ^ pBprev_q;
	always_comb begin
		stepEn = 1'b0;
		stepUp = countDirection_q;
		case (mode)
			MODE_X2_INDEX, MODE_X2_MATCH: begin
				stepEn = edgeA;
				stepUp = pA ^ pB;
			end
			MODE_X4_INDEX, MODE_X4_MATCH: begin
				stepEn = edgeA | edgeB;
				stepUp = edgeA ? (pA ^ pB) : ~(pA ^ pB);
			end
			MODE_TIMER: begin
				stepEn = pA & ~pAprev_q;
				stepUp = encoderControlRegister[CTL_DSRC_BIT] ? pB
						: encoderControlRegister[CTL_DIR_BIT];
			end
			default: begin
				stepEn = 1'b0;
				stepUp = countDirection_q;
			end
		endcase
		if (cpuSleep) begin
			stepEn = 1'b0;
		end
	end

	assign useIndex = (mode == MODE_X2_INDEX) || (mode == MODE_X4_INDEX);
	assign useMatch = (mode == MODE_X2_MATCH) || (mode == MODE_X4_MATCH);
	assign isMatch  = positionCount_q == maximumCountRegister;

	// position counter; no clear on mode change keeps the count
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			positionCount_q <= POS_RESET;
		end else if (useIndex && pI && !pIprev_q && !cpuSleep) begin
			positionCount_q <= POS_RESET;
		end else if (stepEn) begin
			if ((useMatch || mode == MODE_TIMER) && stepUp && isMatch) begin
				positionCount_q <= POS_RESET;
			end else if (useMatch && !stepUp && positionCount_q == POS_RESET) begin
				positionCount_q <= maximumCountRegister;
			end else begin
				positionCount_q <= stepUp ? positionCount_q + 16'h0001
						: positionCount_q - 16'h0001;
			end
		end
	end

	// direction status and match pulse
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			countDirection_q <= 1'b0;
			matchEvent_q     <= 1'b0;
		end else begin
			if (stepEn) begin
				countDirection_q <= stepUp;
			end
			matchEvent_q <= (mode == MODE_TIMER) && stepEn && isMatch;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	chk_sleep_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		cpuSleep |=> positionCount_q == $past(positionCount_q))
		else $error("count moved in sleep");
	chk_off_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		mode == MODE_OFF |=> positionCount_q == $past(positionCount_q))
		else $error("count moved while off");
	chk_timer_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		mode == MODE_TIMER && stepEn && stepUp && isMatch |=> positionCount_q == 16'h0000)
		else $error("timer no restart");
	chk_timer_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		matchEvent_q |-> $past(mode) == MODE_TIMER && $past(isMatch))
		else $error("bad match flag");
	chk_down_roll: assert property (@(posedge clk_sys) disable iff (!resetn)
		useMatch && stepEn && !stepUp && positionCount_q == 16'h0000
		|=> positionCount_q == $past(maximumCountRegister))
		else $error("no roll to max");
	chk_index_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		useIndex && pI && !pIprev_q && !cpuSleep |=> positionCount_q == 16'h0000)
		else $error("index did not clear");
	chk_x2_ignore_b: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode == MODE_X2_INDEX || mode == MODE_X2_MATCH) && !edgeA && !(pI && !pIprev_q)
		|=> $stable(positionCount_q))
		else $error("x2 counted without A edge");
	chk_flt_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
		!brownOutResetn |=> !fltEn_q)
		else $error("filter not disabled");
	chk_dir_timer: assert property (@(posedge clk_sys) disable iff (!resetn)
		mode == MODE_TIMER && stepEn && !cpuSleep |=> countDirection_q == $past(stepUp))
		else $error("timer direction wrong");

	// an edge that the decoder takes must move the count; zero is left out
	// because a roll onto a zero maximum may land on the value it started from
	chk_x4_step: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode == MODE_X4_INDEX || mode == MODE_X4_MATCH) && stepEn
		&& positionCount_q != 16'h0000
		|=> positionCount_q != $past(positionCount_q))
		else $error("x4 edge not counted");
	chk_x2_step: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode == MODE_X2_INDEX || mode == MODE_X2_MATCH) && stepEn
		&& positionCount_q != 16'h0000
		|=> positionCount_q != $past(positionCount_q))
		else $error("x2 edge not counted");

	// direction status follows the level of the other phase at the counted edge
	chk_x2_dir: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode == MODE_X2_INDEX || mode == MODE_X2_MATCH) && edgeA && !cpuSleep
		|=> countDirection_q == ($past(pA) ^ $past(pB)))
		else $error("x2 direction wrong");
	chk_x4_dir_b: assert property (@(posedge clk_sys) disable iff (!resetn)
		(mode == MODE_X4_INDEX || mode == MODE_X4_MATCH) && !edgeA && edgeB && !cpuSleep
		|=> countDirection_q == ($past(pA) ~^ $past(pB)))
		else $error("x4 direction on B wrong");
	chk_dir_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		!stepEn |=> $stable(countDirection_q))
		else $error("direction moved without a step");

	// wrap points and timer behaviour
	chk_up_roll: assert property (@(posedge clk_sys) disable iff (!resetn)
		useMatch && stepEn && stepUp && isMatch |=> positionCount_q == 16'h0000)
		else $error("no roll to zero");
	chk_timer_match: assert property (@(posedge clk_sys) disable iff (!resetn)
		mode == MODE_TIMER && stepEn && isMatch |=> matchEvent_q)
		else $error("match flag missing");
	chk_timer_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
		mode == MODE_TIMER && !(pA && !pAprev_q) |=> $stable(positionCount_q))
		else $error("timer counted without a rising A");
	// only a step or an index clear may touch the count, so a mode change keeps it
	chk_keep_count: assert property (@(posedge clk_sys) disable iff (!resetn)
		!stepEn && !(useIndex && pI && !pIprev_q && !cpuSleep)
		|=> $stable(positionCount_q))
		else $error("count moved without a step");

	// a filtered level changes only after three equal samples; a brown-out
	// clear that lands in between is let through
	chk_flt_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		fltEn_q && rstAll |=> !rstAll || $stable(oA_q) || $past(fA_q) == {oA_q, oA_q})
		else $error("phase A filter changed early");
	chk_flt_hold_b: assert property (@(posedge clk_sys) disable iff (!resetn)
		fltEn_q && rstAll |=> !rstAll || $stable(oB_q) || $past(fB_q) == {oB_q, oB_q})
		else $error("phase B filter changed early");
	chk_flt_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
		!fltEn_q && rstAll |=> !rstAll || oA_q == $past(sA_q[1]))
		else $error("idle filter lost the pin level");
	chk_div_tick: assert property (@(posedge clk_sys) disable iff (!resetn)
		fltTick && filterControlRegister[FLT_DIV_MSB:FLT_DIV_LSB] != 3'h0
		|=> !fltTick || filterControlRegister[FLT_DIV_MSB:FLT_DIV_LSB] == 3'h0)
		else $error("filter tick too soon");
endmodule : qenc_encoder_interface
`default_nettype wire

/* dv/qei_encoder_model.sv */
`default_nettype none
module qenc_encoder_model (
	input  wire logic clk_sys,
	input  wire logic stepReq,
	input  wire logic stepUp,
	input  wire logic indexReq,
	output logic      phaseA,
	output logic      phaseB,
	output logic      indexPulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_q = 2'h0;
	initial indexPulse = 1'b0;
	// gray sequence: only one phase moves per step, A leads B going up
	always @(posedge clk_sys) begin
		if (stepReq)
			phase_q <= stepUp ? phase_q + 2'h1 : phase_q - 2'h1;
		indexPulse <= indexReq;
	end
	assign phaseA = phase_q[1] ^ phase_q[0];
	assign phaseB = phase_q[1];
endmodule : qenc_encoder_model
`default_nettype wire

/* dv/quadrature_encoder_interface_tb_top.sv */
`default_nettype none
module quadrature_encoder_interface_tb_top
	import qenc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, resetn = 1'b0, brownOutn = 1'b1, fltEn = 1'b0, slpIn = 1'b0;
	logic stepReq = 1'b0, stepUp = 1'b0, indexReq = 1'b0, pA, pB, pI;
	logic [15:0] ctl = 16'h0000, fltCtl = 16'h0000, maxR = 16'h0000, rnd = 16'h8E35;
	logic [15:0] positionCount_q;
	logic countDirection_q, matchEvent_q;
	logic [2:0] md = MODE_OFF;
	logic [2:0] mlist [4] = '{MODE_X4_INDEX, MODE_X4_MATCH, MODE_X2_INDEX, MODE_X2_MATCH};
	bit a, dirb, dsrc, slp;
	int pos, mx, ph, cycles, n_compared, err_count;
	int wt = 8;
	qenc_encoder_model u_enc (.clk_sys(clk_sys), .stepReq(stepReq), .stepUp(stepUp),
		.indexReq(indexReq), .phaseA(pA), .phaseB(pB), .indexPulse(pI));
	qenc_encoder_interface u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.brownOutResetn(brownOutn),
		.encoderControlRegister(ctl), .filterControlRegister(fltCtl),
		.filterOutputEnable(fltEn), .maximumCountRegister(maxR), .cpuSleep(slpIn),
		.phaseAInput(pA), .phaseBInput(pB), .indexInput(pI), .positionCount_q(positionCount_q),
		.countDirection_q(countDirection_q), .matchEvent_q(matchEvent_q));
	always #4 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// a hang counts as a mismatch
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next
	// md[2] quadrature, md[1] x4, md[0] match variant
	task automatic do_step(input bit up);
		bit na, nb, cnt, cup, em, sm;
		ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
		na = ph == 1 || ph == 2;
		nb = ph >= 2;
		cnt = !slp && (md[2] ? (md[1] || na != a) : (md == MODE_TIMER && na && !a));
		cup = (md == MODE_TIMER) ? (dsrc ? nb : dirb) : up;
		em = cnt && md == MODE_TIMER && pos == mx;
		if (cnt) begin
			// a period match restarts the timer only while counting up
			if ((md == MODE_TIMER || (md[2] && md[0])) && cup && pos == mx)
				pos = 0;
			else if (md[2] && md[0] && !cup && pos == 0)
				pos = mx;
			else
				pos = (cup ? pos + 1 : pos + 65535) % 65536;
		end
		a = na;
		sm = 0;
		@(posedge clk_sys);
		stepReq <= 1'b1;
		stepUp <= up;
		@(posedge clk_sys);
		stepReq <= 1'b0;
		repeat (wt) begin
			@(posedge clk_sys);
			sm |= matchEvent_q;
		end
		check(positionCount_q, pos[15:0]);
		check({15'h0, sm}, {15'h0, em});
		if (cnt)
			check({15'h0, countDirection_q}, {15'h0, cup});
	endtask : do_step
	task automatic set_mode(input logic [2:0] m, input bit d, input bit s);
		@(posedge clk_sys);
		ctl <= {4'h0, d, m, 7'h00, s};
		md = m;
		dirb = d;
		dsrc = s;
		repeat (4) @(posedge clk_sys);
		check(positionCount_q, pos[15:0]);
	endtask : set_mode
	task automatic set_max(input int v);
		mx = v;
		@(posedge clk_sys);
		maxR <= mx[15:0];
	endtask : set_max
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check(positionCount_q, 16'h0000);
		// every measurement mode, biased upward to reach the maximum, then back down
		foreach (mlist[i]) begin
			set_mode(mlist[i], 0, 0);
			rnd = lfsr_next(rnd);
			set_max(rnd[2:0] + 3);
			repeat (24) begin
				rnd = lfsr_next(rnd);
				do_step(rnd[0] | rnd[1]);
			end
			repeat (6) do_step(0);
			@(posedge clk_sys);
			indexReq <= 1'b1;
			repeat (4) @(posedge clk_sys);
			indexReq <= 1'b0;
			repeat (wt) @(posedge clk_sys);
			if (mlist[i][0] == 1'b0)
				pos = 0;
			check(positionCount_q, pos[15:0]);
		end
		// timer: bit direction, pin direction, then counting down away from the period
		set_mode(MODE_TIMER, 1, 0);
		set_max(pos + 3);
		repeat (20) do_step(1);
		set_mode(MODE_TIMER, 0, 1);
		repeat (16) do_step(0);
		set_max(16'hFFF0);
		set_mode(MODE_TIMER, 0, 0);
		repeat (12) do_step(1);
		// sleep and mode off refuse steps; a full cycle leaves the pins as they were
		set_mode(MODE_X4_INDEX, 0, 0);
		slpIn <= 1'b1;
		slp = 1;
		repeat (4) do_step(1);
		slpIn <= 1'b0;
		slp = 0;
		set_mode(MODE_OFF, 0, 0);
		repeat (4) do_step(0);
		// filtered path, divide field 1; the longer wait covers the filter delay
		set_mode(MODE_X4_INDEX, 0, 0);
		fltEn <= 1'b1;
		fltCtl <= 16'h0010;
		wt = 30;
		repeat (8) begin
			rnd = lfsr_next(rnd);
			do_step(rnd[0]);
		end
		brownOutn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		brownOutn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(positionCount_q, pos[15:0]);
		while (ph != 0) do_step(1);
		// second reset with both phases low so no stale edge is seen
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		pos = 0;
		check(positionCount_q, 16'h0000);
		complete_run();
	end
endmodule : quadrature_encoder_interface_tb_top
`default_nettype wire
